// *** rtl/sars_hst.sv ***
// sars_hst: host end; frames one exchange and delivers the result word
// assumes: one request at a time; user drains results through a valid/ready port
`timescale 1ns/1ps
module sars_hst
  import sars_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  sars_link_if.hst link,
  input wire logic start,
  output logic busy,
  output logic res_valid,
  input wire logic res_ready,
  output logic [RES_W-1:0] res_data
);
  typedef struct packed {
    sars_hst_t fsm;
    logic [7:0] cnt;
    logic [4:0] nclk;
    logic [RES_W-1:0] shreg;
    logic cs_n;
    logic sclk;
    logic push;
  } sars_hst_st_t;
  sars_hst_st_t st;
  sars_hst_st_t next_st;
  logic buf_ready;
  // ==========================================================
  // link sequencer
  assign link.cs_n = st.cs_n;
  assign link.sclk = st.sclk;
  assign busy = (st.fsm != SARS_IDLE);
  always_comb begin
    next_st = st;
    next_st.push = 1'b0;
    unique case (st.fsm)
      SARS_IDLE: begin
        if (start && buf_ready) begin
          next_st.cs_n = 1'b0;
          next_st.cnt = WAKE_CNT;
          next_st.nclk = SLOT_ZERO;
          next_st.fsm = SARS_WAKE;
        end
      end
      SARS_WAKE: begin
        // no clock until the device is awake
        if (st.cnt == CNT_ZERO) begin
          next_st.sclk = 1'b1;
          next_st.cnt = HALF_CNT;
          next_st.fsm = SARS_HIGH;
        end else begin
          next_st.cnt = 8'(st.cnt - 8'h01);
        end
      end
      SARS_HIGH: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.sclk = 1'b0;
          next_st.cnt = HALF_CNT;
          next_st.nclk = 5'(st.nclk + 5'h01);
          next_st.fsm = SARS_LOW;
        end else begin
          next_st.cnt = 8'(st.cnt - 8'h01);
        end
      end
      SARS_LOW: begin
        if (st.cnt == CNT_ZERO) begin
          // sample between falls; first fall gives the null bit
          if (st.nclk != NULL_SLOT) begin
            next_st.shreg = {st.shreg[RES_W-2:0], link.dout};
          end
          // null bit plus twelve result bits have been clocked
          if (st.nclk == 5'(MSB_LAST + NULL_SLOT)) begin
            // MSB-first word complete; stop clocking, end the frame
            next_st.cs_n = 1'b1;
            next_st.push = 1'b1;
            next_st.fsm = SARS_DONE;
          end else begin
            next_st.sclk = 1'b1;
            next_st.cnt = HALF_CNT;
            next_st.fsm = SARS_HIGH;
          end
        end else begin
          next_st.cnt = 8'(st.cnt - 8'h01);
        end
      end
      SARS_DONE: begin
        next_st.fsm = SARS_IDLE;
      end
      default: begin
        next_st.fsm = SARS_IDLE;
        next_st.cs_n = 1'b1;
        next_st.sclk = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '0;
      st.cs_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================================
  // result buffer; start is refused while it is full, so no word is lost
  sars_buf2 u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(st.push),
    .in_ready(buf_ready),
    .in_data(st.shreg),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );
endmodule

// *** rtl/sars_pkg.sv ***
// sars_pkg: shared constants and types for the serial result shifter link
// assumes: both ends run on one 200 MHz clock, mclk, with synchronous active-low nrst
package sars_pkg;
  // ==========================================================
  // result and frame layout
  localparam int RES_W = 12;
  localparam logic [4:0] NULL_SLOT = 5'h01;
  localparam logic [4:0] MSB_LAST = 5'h0C;
  localparam logic [4:0] LSB_LAST = 5'h17;
  localparam logic [4:0] SLOT_ZERO = 5'h00;
  // ==========================================================
  // host timing: shift clock half period and wake-up wait
  localparam int MCLK_MHZ = 200;
  localparam int HALF_NS = 50;
  localparam int HALF_CYC = (HALF_NS * MCLK_MHZ + 999) / 1000;
  localparam int WAKE_SETUP_NS = 100;
  localparam int WAKE_CYC = (WAKE_SETUP_NS * MCLK_MHZ + 999) / 1000;
  localparam logic [7:0] HALF_CNT = 8'(HALF_CYC - 1);
  localparam logic [7:0] WAKE_CNT = 8'(WAKE_CYC - 1);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
  // ==========================================================
  // host sequencer states
  typedef enum logic [2:0] {
    SARS_IDLE = 3'b000,
    SARS_WAKE = 3'b001,
    SARS_HIGH = 3'b010,
    SARS_LOW = 3'b011,
    SARS_DONE = 3'b100
  } sars_hst_t;
endpackage

// *** rtl/sars_link_if.sv ***
// sars_link_if: three-wire link between host and converter
// assumes: host drives select and shift clock, device drives data with an enable
`timescale 1ns/1ps
interface sars_link_if;
  logic cs_n;
  logic sclk;
  logic dout;
  logic dout_oe;
  modport dev (input cs_n, input sclk, output dout, output dout_oe);
  modport hst (input dout, input dout_oe, output cs_n, output sclk);
endinterface

// *** rtl/sars_buf2.sv ***
// sars_buf2: two-entry valid/ready buffer for result words
// assumes: one clock domain, synchronous active-low reset
`timescale 1ns/1ps
module sars_buf2
  import sars_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [RES_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [RES_W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][RES_W-1:0] mem;
    logic [1:0] cnt;
    logic rd;
    logic wr;
  } sars_buf_t;
  sars_buf_t st;
  sars_buf_t next_st;
  logic push;
  logic pop;
  // ==========================================================
  // handshake
  assign in_ready = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data = st.mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = ~st.wr;
    end
    if (pop) begin
      next_st.rd = ~st.rd;
    end
    next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** rtl/sars_dev.sv ***
// sars_dev: converter end; conversion control and serial result shifter
// assumes: link pins synchronous to mclk; an analog comparator answer arrives on cmp_hi
//
// Behaviour
// - three wires: select, shift clock, data out
// - each bit changes on shift clock fall
// - no configuration, no data input
// - select falling starts conversion and transfer
// - host waits wake setup before first clock
// - output enabled on first clock pulse
// - null bit, MSB-first, then LSB-first
// - twelve-bit successive approximation result
// - shifted bits come from current conversion
// - select high resets control logic
// - select high enters low-power shutdown
// - late-select host gets right-justified bytes; here every frame opens with the null bit then B11, never right-justified
// - early host gets B11..B6 then B5..B0,B1,B2
// - select active low
`timescale 1ns/1ps
module sars_dev
  import sars_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  sars_link_if.dev link,
  input wire logic cmp_hi,
  output logic [RES_W-1:0] dac_code,
  output logic shutdown,
  output logic sample
);
  typedef struct packed {
    logic sclk_d;
    logic active;
    logic oe;
    logic [4:0] slot;
    logic [RES_W-1:0] sar;
    logic bit_out;
    logic pwr_dn;
  } sars_dev_t;
  sars_dev_t st;
  sars_dev_t next_st;
  logic fall;
  logic [3:0] idx;
  // ==========================================================
  // conversion and shifting
  assign fall = st.sclk_d && !link.sclk;
  // trial code: decided bits plus the bit under test, so the dac sees it this period
  assign idx = 4'(st.slot - MSB_LAST);
  assign dac_code = st.sar;
  assign link.dout = st.bit_out;
  assign link.dout_oe = st.oe;
  assign shutdown = st.pwr_dn;
  assign sample = st.active && !st.oe;
  always_comb begin
    next_st = st;
    next_st.sclk_d = link.sclk;
    if (link.cs_n) begin
      // abandon any transfer; nothing else needed to be ready for the next select
      next_st.active = 1'b0;
      next_st.oe = 1'b0;
      next_st.slot = SLOT_ZERO;
      next_st.bit_out = 1'b0;
      next_st.pwr_dn = 1'b1;
    end else begin
      next_st.pwr_dn = 1'b0;
      if (!st.active) begin
        // fresh conversion; no command word is read
        next_st.active = 1'b1;
        next_st.sar = RES_ZERO;
        next_st.sar[RES_W-1] = 1'b1;
      end else if (fall) begin
        // only falling edges move the output
        next_st.oe = 1'b1;
        // the slot parks one past the LSB-first word, so B11 of that word still goes out
        if (st.slot <= LSB_LAST) begin
          next_st.slot = 5'(st.slot + 5'h01);
        end
        if (st.slot == SLOT_ZERO) begin
          next_st.bit_out = 1'b0; // null bit
        end else if (st.slot < MSB_LAST) begin
          // decide the bit under test, emit it, arm the next trial
          next_st.sar[RES_W - 32'(st.slot)] = cmp_hi;
          next_st.bit_out = cmp_hi;
          next_st.sar[RES_W - 1 - 32'(st.slot)] = 1'b1;
        end else if (st.slot == MSB_LAST) begin
          next_st.sar[0] = cmp_hi;
          next_st.bit_out = cmp_hi;
        end else if (st.slot <= LSB_LAST) begin
          // LSB-first repeat starts at B1; B0 was just sent
          next_st.bit_out = st.sar[idx];
        end else begin
          // past the end the line holds low until select rises
          next_st.bit_out = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st <= '0;
      st.pwr_dn <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** dv/sars_link_sva.sv ***
// link checker: timing of the three-wire link
// assumes: placed beside the interface, one mclk domain
`timescale 1ns/1ps
module sars_link_sva
  import sars_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe
);
  // ==========
  // falls and selected cycles of a frame
  logic [4:0] nf;
  logic [7:0] sc;
  always_ff @(posedge mclk) begin
    if (!nrst || cs_n) begin
      nf <= 5'h00;
      sc <= 8'h00;
    end else begin
      nf <= nf + 5'($fell(sclk));
      sc <= sc + 8'(sc != 8'hFF);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========
  // link checks
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("clock while idle");
  a_wake_wait: assert property ($rose(sclk) && nf == 5'h00 |-> int'(sc) >= WAKE_CYC)
    else $error("wake wait short");
  a_dout_on_fall: assert property ($changed(dout) |-> !sclk)
    else $error("data moved in high half");
  a_null_first: assert property ($rose(dout_oe) |-> !dout && !sclk)
    else $error("no null bit");
  a_oe_held: assert property ($fell(cs_n) |-> !dout_oe [*8])
    else $error("output on early");
  a_oe_on_fall: assert property ($fell(sclk) && !cs_n |-> ##[1:3] dout_oe)
    else $error("output not on");
  a_oe_off: assert property (cs_n [*3] |-> !dout_oe)
    else $error("output on when idle");
  a_host_stops: assert property ($rose(cs_n) |-> nf == 5'h0D)
    else $error("fall count");
  c_frame: cover property ($rose(cs_n) && nf == 5'h0D);
  c_one: cover property (dout_oe && dout);
  c_null: cover property ($rose(dout_oe));
endmodule

// *** dv/serial_adc_result_shifter_bench.sv ***
// bench: host end against converter end, plus a second converter driven by hand
// assumes: sars_pkg timing constants, one 200 MHz mclk
`timescale 1ns/1ps
`define SARS_CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t %s", $time, m); end end
module serial_adc_result_shifter_bench;
  import sars_pkg::*;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic start = 1'h0;
  logic res_ready = 1'h0;
  logic drain = 1'h0;
  logic busy, res_valid, shut1, shut2, samp2;
  logic [RES_W-1:0] vin = 12'h000;
  logic [RES_W-1:0] res_data, dac, dac2, wbits;
  logic [RES_W-1:0] exp_q[$];
  int err_count = 0;
  int n_compared = 0;
  int nbits = 0;
  int k;
  sars_link_if link();
  sars_link_if link2();
  always #2.5 mclk = ~mclk;
  // input sits half a step above vin, so the code converges on vin
  sars_dev sars_dev_i(.mclk(mclk), .nrst(nrst), .link(link), .cmp_hi(vin >= dac), .dac_code(dac),
    .shutdown(shut1), .sample());
  sars_dev sars_dev_i2(.mclk(mclk), .nrst(nrst), .link(link2), .cmp_hi(vin >= dac2), .dac_code(dac2),
    .shutdown(shut2), .sample(samp2));
  sars_hst sars_hst_i(.mclk(mclk), .nrst(nrst), .link(link), .start(start), .busy(busy),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  sars_link_sva sars_link_sva_i(.mclk(mclk), .nrst(nrst), .cs_n(link.cs_n), .sclk(link.sclk),
    .dout(link.dout), .dout_oe(link.dout_oe));
  // ==========
  // result side: random stalls, oldest note compared
  always @(posedge mclk) begin
    res_ready <= drain & 1'($urandom_range(1));
  end
  // looked at mid-period, where the handshake that the next rise takes has settled
  always @(negedge mclk) begin
    if (nrst && res_valid && res_ready) `SARS_CHK(res_data, exp_q.pop_front(), "word")
  end
  // wire side: bits seen at each rise and at deselect
  always @(posedge link.sclk or posedge link.cs_n) begin
    if (link.dout_oe === 1'h1) begin
      wbits = {wbits[RES_W-2:0], link.dout};
      nbits++;
    end
    if (link.cs_n === 1'h1 && nbits > 0) begin
      `SARS_CHK({wbits, 4'(nbits)}, {vin, 4'hD}, "wire")
      nbits = 0;
    end
  end
  task automatic frame(input logic [RES_W-1:0] v, input logic take);
    int w;
    @(posedge mclk);
    vin <= v;
    start <= 1'h1;
    if (take) exp_q.push_back(v);
    @(posedge mclk);
    start <= 1'h0;
    @(posedge mclk);
    @(posedge mclk);
    `SARS_CHK({busy, shut1}, {take, !take}, "busy")
    for (w = 0; w < 400 && busy === 1'h1; w++) begin
      @(posedge mclk);
    end
  endtask
  task automatic pulse;
    link2.sclk <= 1'h1;
    repeat (HALF_CYC) @(posedge mclk);
    link2.sclk <= 1'h0;
    repeat (HALF_CYC) @(posedge mclk);
  endtask
  // pre pulses come while idle and must be ignored; a short frame is an abort
  task automatic raw(input logic [RES_W-1:0] v, input int pre, input int nf);
    logic [23:0] got, ex;
    int i;
    ex = 24'({1'h0, v});
    for (i = 1; i < RES_W; i++) begin
      ex = {ex[22:0], v[i]};
    end
    vin <= v;
    repeat (pre) pulse();
    link2.cs_n <= 1'h0;
    repeat (WAKE_CYC) @(posedge mclk);
    `SARS_CHK({link2.dout_oe, shut2, samp2}, 3'h1, "wake")
    for (i = 0; i < nf; i++) begin
      pulse();
      got = {got[22:0], link2.dout};
    end
    if (nf == 24) `SARS_CHK(got, ex, "two orders")
    link2.cs_n <= 1'h1;
    repeat (4) @(posedge mclk);
    `SARS_CHK({link2.dout_oe, shut2, samp2}, 3'h2, "deselect")
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0A3A));
    link2.cs_n = 1'h1;
    link2.sclk = 1'h0;
    repeat (8) @(posedge mclk);
    nrst <= 1'h1;
    frame(12'h000, 1'h1);
    frame(12'hFFF, 1'h1);
    frame(12'h5A5, 1'h0);
    drain <= 1'h1;
    for (k = 0; k < 200 && exp_q.size() != 0; k++) begin
      @(posedge mclk);
    end
    frame(12'h800, 1'h1);
    frame(12'h7FF, 1'h1);
    repeat (3) frame(12'($urandom), 1'h1);
    raw(12'($urandom), 0, 24);
    raw(12'hA5C, 2, 5);
    raw(12'h3C3, 2, 24);
    for (k = 0; k < 200 && exp_q.size() != 0; k++) begin
      @(posedge mclk);
    end
    `SARS_CHK(exp_q.size(), 0, "left over")
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("MISMATCH %0t watchdog", $time);
    tally_and_finish();
  end
endmodule
